// ### hw/resampler_defines.svh
`ifndef RESAMPLER_DEFINES_SVH
`define RESAMPLER_DEFINES_SVH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define CLK_SYS_MHZ        25
// Horizontal reset pulse width in ns, and its cycle count rounded up
`define LINE_RST_TIME_NS   4700
`define LINE_RST_CYC       ((`LINE_RST_TIME_NS * `CLK_SYS_MHZ + 999) / 1000)

// ==========================================================================
// Samples per nominal line at the single rate, and square-pixel counts
// ==========================================================================
`define NOM_SAMPLES_525    12'h038e
`define NOM_SAMPLES_625    12'h046f
`define SQ_PIXELS_525      12'h030c
`define SQ_PIXELS_625      12'h03b0

// ==========================================================================
// Format-select codes
// ==========================================================================
`define FMT_NTSC_M         3'h1
`define FMT_NTSC_JAPAN     3'h2
`define FMT_PAL_BDGHI      3'h3
`define FMT_PAL_M          3'h4
`define FMT_PAL_N          3'h5
`define FMT_SECAM          3'h6
`define FMT_PAL_N_COMB     3'h7

// ==========================================================================
// Crystal-select codes
// ==========================================================================
`define XTAL_FIRST         2'h1
`define XTAL_SECOND        2'h2

// ==========================================================================
// Subcarrier frequencies in kHz
// ==========================================================================
`define FSC_KHZ_358        13'h0dfc
`define FSC_KHZ_443        13'h114e
`define FSC_KHZ_4406       13'h1136
`define FSC_KHZ_4250       13'h109a

`endif

// ### hw/resampler_pkg.sv
`include "resampler_defines.svh"

package resampler_pkg;

  // ========================================================================
  // Line-lock states, one-hot
  // ========================================================================
  typedef enum logic [3:0] {
    ST_HUNT    = 4'b0001,  // No sync seen yet
    ST_MEASURE = 4'b0010,  // First line, length only
    ST_RUN     = 4'b0100,  // Resampling
    ST_FLUSH   = 4'b1000   // Topping up a short line
  } lock_state_t;

  // ========================================================================
  // Decoded video standard
  // ========================================================================
  typedef struct packed {
    logic        lines_625;    // 625/50 when set, else 525/60
    logic        setup_zero;   // No pedestal
    logic [1:0]  xtal_expect;  // Crystal that suits the standard
    logic [12:0] fsc_khz;      // Main subcarrier
    logic [12:0] fsc_alt_khz;  // Second subcarrier (SECAM only)
  } std_info_t;

  // Format code to standard; unknown codes fall back to 525 lines
  function automatic std_info_t decode_std(input logic [2:0] fmt);
    std_info_t s;
    s = '{1'b0, 1'b0, `XTAL_FIRST, `FSC_KHZ_358, `FSC_KHZ_358};
    case (fmt)
      `FMT_NTSC_JAPAN: s.setup_zero = 1'b1;
      `FMT_PAL_M: begin
        // Single subcarrier, so the second one mirrors the main
        s.fsc_khz     = `FSC_KHZ_443;
        s.fsc_alt_khz = `FSC_KHZ_443;
      end
      `FMT_PAL_BDGHI, `FMT_PAL_N: begin
        s = '{1'b1, 1'b0, `XTAL_SECOND, `FSC_KHZ_443, `FSC_KHZ_443};
      end
      `FMT_SECAM: begin
        s = '{1'b1, 1'b0, `XTAL_SECOND, `FSC_KHZ_4406, `FSC_KHZ_4250};
      end
      `FMT_PAL_N_COMB: s.lines_625 = 1'b1;
      default: s.lines_625 = 1'b0;
    endcase
    return s;
  endfunction : decode_std

endpackage : resampler_pkg

// ### hw/sample_if.sv
// ==========================================================================
// Single-rate sample stream between decimator and resampler
// ==========================================================================
interface sample_if #(parameter int W = 10);
  logic [W-1:0] data;   // Decimated sample
  logic         valid;  // One-cycle pulse per single-rate sample
  modport src (output data, output valid);
  modport snk (input data, input valid);
endinterface : sample_if

// ### hw/half_rate_decimator.sv
// ==========================================================================
// Two-tap low-pass and decimate by two, plus the single-rate enable
// ==========================================================================
module half_rate_decimator #(
  parameter int W = 10
) (
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] raw_sample_i,
  output logic              single_rate_clk_o,
  sample_if.src             out
);

  logic         phase_q, phase_d;  // Divider phase
  logic [W-1:0] hold_q, hold_d;    // Even sample
  logic [W-1:0] avg_q, avg_d;      // Filtered output
  logic         vld_q, vld_d;      // Output strobe
  logic [W:0]   sum;               // Pair sum, one bit wider

  // Next-state: average each pair, strobe on the odd phase
  always_comb begin
    sum     = {1'b0, hold_q} + {1'b0, raw_sample_i};
    phase_d = ~phase_q;
    hold_d  = phase_q ? hold_q : raw_sample_i;
    avg_d   = phase_q ? sum[W:1] : avg_q;
    vld_d   = phase_q;
  end

  // Registers only
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      phase_q <= 1'b0;
      hold_q  <= '0;
      avg_q   <= '0;
      vld_q   <= 1'b0;
    end else begin
      phase_q <= phase_d;
      hold_q  <= hold_d;
      avg_q   <= avg_d;
      vld_q   <= vld_d;
    end
  end

  assign out.data          = avg_q;
  assign out.valid         = vld_q;
  // Divided clock is the phase flop itself, so it is glitch free
  assign single_rate_clk_o = phase_q;

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  div_alternate_a: assert property (vld_q |=> !vld_q ##1 vld_q)
    else $error("single-rate strobe does not alternate");
  decim_average_a: assert property (
    phase_q |=> avg_q == W'(({1'b0, $past(hold_q)} + {1'b0, $past(raw_sample_i)}) >> 1))
    else $error("decimated sample is not the pair average");

endmodule : half_rate_decimator

// ### hw/line_locked_pixel_resampler.sv
`include "resampler_defines.svh"

module line_locked_pixel_resampler #(
  parameter int W  = 10,  // Sample width
  parameter int LW = 12   // Line and pixel count width
) (
  input  wire logic          clk_sys_i,
  input  wire logic          nrst_i,
  input  wire logic [W-1:0]  video_sample_i,
  input  wire logic          hsync_n_i,
  input  wire logic          subcarrier_lock_i,
  input  wire logic [2:0]    format_sel_i,
  input  wire logic [1:0]    crystal_source_select_i,
  input  wire logic [LW-1:0] pixel_target_i,
  output logic               single_rate_sample_clock_o,
  output logic               double_rate_crystal_clock_o,
  output logic [W-1:0]       pixel_o,
  output logic               pixel_valid_o,
  output logic               horizontal_line_reset_o,
  output logic               line_lock_o,
  output logic               lines_625_o,
  output logic               setup_zero_o,
  output logic [12:0]        fsc_khz_o,
  output logic [12:0]        fsc_alt_khz_o,
  output logic               crystal_mismatch_o,
  output logic [LW-1:0]      nominal_samples_o,
  output logic [LW-1:0]      line_length_o
);

  // ========================================================================
  // Decimator
  // ========================================================================
  sample_if #(.W(W)) smp ();  // Single-rate stream
  logic single_clk;           // Divided clock level

  half_rate_decimator #(.W(W)) u_decim (
    .clk_sys_i         (clk_sys_i),
    .nrst_i            (nrst_i),
    .raw_sample_i      (video_sample_i),
    .single_rate_clk_o (single_clk),
    .out               (smp.src)
  );

  localparam logic [7:0] HR_CYC = 8'(`LINE_RST_CYC);  // Reset pulse length

  // ========================================================================
  // State
  // ========================================================================
  resampler_pkg::lock_state_t state_q, state_d;  // Lock FSM
  resampler_pkg::std_info_t   std_q, std_d;      // Decoded standard
  logic [LW-1:0] cnt_q, cnt_d;       // Samples since last sync
  logic [LW-1:0] len_q, len_d;       // Measured line length
  logic [LW-1:0] acc_q, acc_d;       // Phase accumulator
  logic [LW-1:0] pix_q, pix_d;       // Pixels emitted this line
  logic [LW-1:0] tgt_q, tgt_d;       // Target latched per line
  logic [7:0]    hr_q, hr_d;         // Reset pulse counter
  logic [W-1:0]  pixel_q, pixel_d;   // Output pixel
  logic          pv_q, pv_d;         // Output strobe
  logic          hs_q, hs_d;         // Previous sync level
  logic          pend_q, pend_d;     // Sync edge awaiting a tick
  logic          lock_q, lock_d;     // Lock indication
  logic          mism_q, mism_d;     // Crystal does not suit format
  logic          dbl_q;              // Double-rate strobe, high after reset
  logic          evt;                // Sync edge on a single-rate tick
  logic [LW-1:0] nom;                // Nominal samples for the standard
  logic [LW-1:0] tgt_in;             // Requested pixel count
  logic [LW-1:0] max_len;            // Line length that means sync is lost
  logic [LW:0]   step;               // Accumulator plus target

  // ========================================================================
  // Helpers
  // ========================================================================
  // Target loaded for a fresh output line
  function automatic logic [LW-1:0] pick_target(input logic [LW-1:0] req,
                                                input logic           l625);
    // Zero asks for square pixels of the standard
    if (req != '0)
      return req;
    return l625 ? LW'(`SQ_PIXELS_625) : LW'(`SQ_PIXELS_525);
  endfunction : pick_target

  // ========================================================================
  // Standard, lock and sync edge
  // ========================================================================
  always_comb begin
    std_d   = resampler_pkg::decode_std(format_sel_i);
    mism_d  = crystal_source_select_i != std_q.xtal_expect;
    nom     = std_q.lines_625 ? LW'(`NOM_SAMPLES_625) : LW'(`NOM_SAMPLES_525);
    max_len = LW'({nom, 1'b0});
    tgt_in  = pick_target(pixel_target_i, std_q.lines_625);
    hs_d    = hsync_n_i;
    // Sliced sync falls at its midpoint; an edge between ticks waits
    evt     = smp.valid & (pend_q | (hs_q & ~hsync_n_i));
    // A tick uses the edge at once; keeping it pending would fire twice
    pend_d  = ~smp.valid & (pend_q | (hs_q & ~hsync_n_i));
    lock_d  = subcarrier_lock_i &
              ((state_q == resampler_pkg::ST_RUN) | (state_q == resampler_pkg::ST_FLUSH));
  end

  // ========================================================================
  // Line lock and resampling
  // ========================================================================
  // Bresenham stepping: add the target each input sample, emit and
  // subtract the length on overflow. The length is last line's, so a
  // shorter line leaves a few pixels owed; FLUSH pays them before the
  // next line starts, trading a little reset jitter for an exact count.
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    len_d   = len_q;
    acc_d   = acc_q;
    pix_d   = pix_q;
    tgt_d   = tgt_q;
    pixel_d = pixel_q;
    pv_d    = 1'b0;
    hr_d    = (hr_q != '0) ? hr_q - 8'h01 : hr_q;
    step    = {1'b0, acc_q} + {1'b0, tgt_q};
    if (smp.valid && cnt_q != '1)
      cnt_d = cnt_q + LW'(1);
    case (state_q)
      resampler_pkg::ST_HUNT: begin
        if (evt) begin
          cnt_d   = LW'(1);
          state_d = resampler_pkg::ST_MEASURE;
        end
      end
      resampler_pkg::ST_MEASURE: begin
        if (evt) begin
          len_d   = cnt_q;
          cnt_d   = LW'(1);
          acc_d   = '0;
          pix_d   = '0;
          tgt_d   = tgt_in;
          hr_d    = HR_CYC;
          state_d = resampler_pkg::ST_RUN;
        end else if (cnt_q >= max_len) begin
          state_d = resampler_pkg::ST_HUNT;
        end
      end
      resampler_pkg::ST_RUN: begin
        if (evt) begin
          len_d = cnt_q;
          cnt_d = LW'(1);
          if (pix_q < tgt_q) begin
            state_d = resampler_pkg::ST_FLUSH;
          end else begin
            acc_d = '0;
            pix_d = '0;
            tgt_d = tgt_in;
            hr_d  = HR_CYC;
          end
        end else if (cnt_q >= max_len) begin
          state_d = resampler_pkg::ST_HUNT;
        end else if (smp.valid && pix_q < tgt_q) begin
          // More samples than pixels, so at most one pixel per sample
          if (step >= {1'b0, len_q}) begin
            acc_d   = LW'(step - {1'b0, len_q});
            pix_d   = pix_q + LW'(1);
            pixel_d = smp.data;
            pv_d    = 1'b1;
          end else begin
            acc_d = LW'(step);
          end
        end
      end
      resampler_pkg::ST_FLUSH: begin
        if (evt) begin
          state_d = resampler_pkg::ST_HUNT;  // Second sync mid-flush: relock
        end else if (smp.valid) begin
          pix_d = pix_q + LW'(1);
          pv_d  = 1'b1;                      // Repeats the last pixel
          if (pix_q + LW'(1) >= tgt_q) begin
            acc_d   = '0;
            pix_d   = '0;
            tgt_d   = tgt_in;
            hr_d    = HR_CYC;
            state_d = resampler_pkg::ST_RUN;
          end
        end
      end
      default: state_d = resampler_pkg::ST_HUNT;
    endcase
  end

  // Registers only
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      state_q <= resampler_pkg::ST_HUNT;
      std_q   <= '0;
      cnt_q   <= '0;
      len_q   <= '0;
      acc_q   <= '0;
      pix_q   <= '0;
      tgt_q   <= '0;
      hr_q    <= '0;
      pixel_q <= '0;
      pv_q    <= 1'b0;
      hs_q    <= 1'b1;
      pend_q  <= 1'b0;
      lock_q  <= 1'b0;
      mism_q  <= 1'b0;
      dbl_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      std_q   <= std_d;
      cnt_q   <= cnt_d;
      len_q   <= len_d;
      acc_q   <= acc_d;
      pix_q   <= pix_d;
      tgt_q   <= tgt_d;
      hr_q    <= hr_d;
      pixel_q <= pixel_d;
      pv_q    <= pv_d;
      hs_q    <= hs_d;
      pend_q  <= pend_d;
      lock_q  <= lock_d;
      mism_q  <= mism_d;
      dbl_q   <= 1'b1;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  assign single_rate_sample_clock_o  = single_clk;
  assign double_rate_crystal_clock_o = dbl_q;
  assign pixel_o                     = pixel_q;
  assign pixel_valid_o               = pv_q;
  assign horizontal_line_reset_o     = hr_q != '0;
  assign line_lock_o                 = lock_q;
  assign lines_625_o                 = std_q.lines_625;
  assign setup_zero_o                = std_q.setup_zero;
  assign fsc_khz_o                   = std_q.fsc_khz;
  assign fsc_alt_khz_o               = std_q.fsc_alt_khz;
  assign crystal_mismatch_o          = mism_q;
  assign nominal_samples_o           = nom;
  assign line_length_o               = len_q;

  // ========================================================================
  // Checks
  // ========================================================================
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  pix_on_tick_a: assert property (pv_q |-> $past(smp.valid))
    else $error("pixel emitted off a single-rate tick");
  pix_cap_a: assert property (state_q == resampler_pkg::ST_RUN |-> pix_q <= tgt_q)
    else $error("pixel count exceeds target");
  flush_close_a: assert property (state_q == resampler_pkg::ST_FLUSH && !evt
    && smp.valid && pix_q + LW'(1) == tgt_q |=> state_q == resampler_pkg::ST_RUN && pix_q == '0)
    else $error("flush did not close the line at target");
  line_rst_len_a: assert property ($rose(horizontal_line_reset_o) |-> hr_q == HR_CYC)
    else $error("horizontal reset pulse has wrong length");
  len_measure_a: assert property (evt && state_q == resampler_pkg::ST_RUN
    |=> len_q == $past(cnt_q) && cnt_q == LW'(1))
    else $error("line length not taken at sync edge");
  lock_needs_fsc_a: assert property (line_lock_o |-> $past(subcarrier_lock_i))
    else $error("lock shown without subcarrier lock");
  nominal_len_a: assert property (##1 nominal_samples_o ==
    (($past(format_sel_i) inside {`FMT_PAL_BDGHI, `FMT_PAL_N, `FMT_SECAM, `FMT_PAL_N_COMB})
     ? LW'(`NOM_SAMPLES_625) : LW'(`NOM_SAMPLES_525)))
    else $error("nominal samples wrong for standard");
  setup_zero_a: assert property (##1 setup_zero_o == ($past(format_sel_i) == `FMT_NTSC_JAPAN))
    else $error("zero setup flag wrong");
  acc_bound_a: assert property (state_q == resampler_pkg::ST_RUN && tgt_q <= len_q
    |-> acc_q < len_q)
    else $error("phase accumulator out of range");

  flush_seen_c: cover property (state_q == resampler_pkg::ST_RUN ##1
    state_q == resampler_pkg::ST_FLUSH);
  full_line_c: cover property (evt && state_q == resampler_pkg::ST_RUN && pix_q == tgt_q);
  sync_lost_c: cover property (state_q == resampler_pkg::ST_RUN ##1
    state_q == resampler_pkg::ST_HUNT);

endmodule : line_locked_pixel_resampler

// ### tb/video_source_model.sv
// ==========================================================================
// Upstream sampler: sliced sync and raw double-rate samples
// ==========================================================================
module video_source_model #(
  parameter int SYNC_CYC = 118  // Sync tip width in double-rate cycles
) (
  input  wire logic        clk_sys_i,
  input  wire logic        run_i,
  input  wire logic [11:0] line_len_i,
  output logic             hsync_n_o,
  output logic [9:0]       sample_o,
  output logic             line_start_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cyc_q  = 0;  // Position within the line
  int unsigned span_q = 0;  // Line length latched at sync
  initial begin
    hsync_n_o    = 1'b1;
    sample_o     = 10'h000;
    line_start_o = 1'b0;
  end
  // Length is latched at each sync, so a change waits for the next line
  always @(posedge clk_sys_i) begin
    sample_o     <= 10'($urandom);
    line_start_o <= run_i && (cyc_q == 0);
    if (!run_i) begin
      hsync_n_o <= 1'b1;                           // No sync at all: lock must drop
      cyc_q     <= 0;
    end else begin
      if (cyc_q == 0) span_q <= 2 * line_len_i;    // Two raw samples per decimated one
      hsync_n_o <= (cyc_q >= SYNC_CYC);
      cyc_q     <= (cyc_q != 0 && cyc_q + 1 >= span_q) ? 0 : cyc_q + 1;
    end
  end
endmodule : video_source_model

// ### tb/testbench.sv
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {int cnt; int per;} line_exp_t;  // Pixels per line, period or 0
  logic        clk_sys  = 1'b0;
  logic        nrst     = 1'b0;
  logic        sc_lock  = 1'b1;
  logic [2:0]  fmt_sel  = 3'h1;
  logic [1:0]  xtal_sel = 2'h1;
  logic [11:0] pix_tgt  = 12'h000;
  logic        run      = 1'b0;
  logic [11:0] len_sel  = 12'h038e;
  logic        hsync_n, line_start, sr_clk, dr_clk, pix_vld, hl_rst, lock, l625, sz, mism;
  logic [9:0]  video, pixel;
  logic [12:0] fsc, fsc_alt;
  logic [11:0] nom, line_len;
  int          fails = 0, num_checks = 0;
  line_exp_t   exp_q[$];   // Notes from the driver, oldest first
  line_exp_t   e_now;
  int          pix_cnt = 0, cyc = 0, last_rise = 0, last_fall = 0, period = 0, nfall = 0;
  bit          started = 0, hr_prev = 0;
  logic [9:0]  vh[4];                // Raw samples as the design took them, newest first
  logic [9:0]  last_pix = 10'h000;   // Previous output pixel, for flush repeats
  logic [10:0] pair;                 // Sum of the raw pair behind a pixel

  always #20 clk_sys = ~clk_sys;

  line_locked_pixel_resampler DUT (
    .clk_sys_i(clk_sys), .nrst_i(nrst), .video_sample_i(video), .hsync_n_i(hsync_n),
    .subcarrier_lock_i(sc_lock), .format_sel_i(fmt_sel), .crystal_source_select_i(xtal_sel),
    .pixel_target_i(pix_tgt), .single_rate_sample_clock_o(sr_clk),
    .double_rate_crystal_clock_o(dr_clk), .pixel_o(pixel), .pixel_valid_o(pix_vld),
    .horizontal_line_reset_o(hl_rst), .line_lock_o(lock), .lines_625_o(l625),
    .setup_zero_o(sz), .fsc_khz_o(fsc), .fsc_alt_khz_o(fsc_alt), .crystal_mismatch_o(mism),
    .nominal_samples_o(nom), .line_length_o(line_len)
  );
  video_source_model SRC (
    .clk_sys_i(clk_sys), .run_i(run), .line_len_i(len_sel), .hsync_n_o(hsync_n),
    .sample_o(video), .line_start_o(line_start)
  );

  function automatic bit is625(input logic [2:0] f);
    return f inside {3'h3, 3'h5, 3'h6, 3'h7};
  endfunction : is625

  task automatic stop_test();
    $display("checks %0d, failures %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // Bounded wait for the next sync from the source
  task automatic wait_line();
    int k;
    k = 0;
    do begin
      @(negedge clk_sys);
      k++;
    end while (line_start !== 1'b1 && k < 6000);
    `CHECK(line_start, 1'b1)
  endtask : wait_line

  // Divided clock toggles every cycle, double-rate strobe stays high
  task automatic check_clocks();
    logic p;
    @(negedge clk_sys);
    p = sr_clk;
    repeat (4) begin
      @(negedge clk_sys);
      `CHECK(sr_clk, ~p)
      `CHECK(dr_clk, 1'b1)
      p = sr_clk;
    end
  endtask : check_clocks

  // Every format code, with the matching and the wrong crystal
  task automatic check_formats();
    logic [1:0]  xt;
    logic [12:0] fm;
    for (int i = 1; i < 8; i++) begin
      xt = (i == 3 || i == 5 || i == 6) ? 2'h2 : 2'h1;
      fm = (i >= 3 && i <= 5) ? 13'h114e : (i == 6) ? 13'h1136 : 13'h0dfc;
      for (int m = 0; m < 2; m++) begin
        @(posedge clk_sys);
        fmt_sel  <= 3'(i);
        xtal_sel <= (m == 0) ? xt : ~xt;
        repeat (3) @(negedge clk_sys);
        `CHECK(l625, is625(3'(i)))
        `CHECK(sz, 1'(i == 2))
        `CHECK(fsc, fm)
        `CHECK(fsc_alt, (i == 6) ? 13'h109a : fm)
        `CHECK(nom, is625(3'(i)) ? 12'h046f : 12'h038e)
        `CHECK(mism, 1'(m))
      end
    end
  endtask : check_formats

  // Sync gap to drop lock, then n lines; jit 0 means a stable source
  task automatic run_lines(input logic [2:0] f, input logic [11:0] tgt, input int n,
                           input int base, input int jit);
    int want;
    int prev;
    want = (tgt != 0) ? int'(tgt) : (is625(f) ? 944 : 780);
    prev = 0;
    @(posedge clk_sys);
    fmt_sel <= f;
    pix_tgt <= tgt;
    run     <= 1'b0;
    repeat (4700) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHECK(lock, 1'b0)
    started = 0;
    nfall   = 0;
    for (int i = 0; i < n - 2; i++) exp_q.push_back('{want, (jit == 0) ? 2 * base : 0});
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      len_sel <= 12'(base + ((jit == 0) ? 0 : int'($urandom_range(2 * jit)) - jit));
      run     <= 1'b1;
      wait_line();
      repeat (8) @(negedge clk_sys);
      if (i > 0) `CHECK(line_len, 12'(prev))
      if (i == n - 1) `CHECK(lock, 1'b1)
      prev = len_sel;
    end
  endtask : run_lines

  // Output watcher: pixels between line resets against the oldest note
  always @(negedge clk_sys) begin
    cyc++;
    // A pixel shows two edges after the odd sample of its pair
    vh[3] = vh[2];
    vh[2] = vh[1];
    vh[1] = vh[0];
    vh[0] = video;
    pair  = {1'b0, vh[3]} + {1'b0, vh[2]};
    if (pix_vld === 1'b1) begin
      pix_cnt++;
      `CHECK(1'(pixel === pair[10:1] || pixel === last_pix), 1'b1)
      last_pix = pixel;
    end
    if (hl_rst === 1'b1 && !hr_prev) begin
      if (started && exp_q.size() != 0) begin
        e_now = exp_q.pop_front();
        `CHECK(pix_cnt, e_now.cnt)
        if (e_now.per != 0 && nfall >= 2) `CHECK(1'(period >= e_now.per - 2 && period <= e_now.per + 2), 1'b1)
      end
      started   = 1;
      pix_cnt   = 0;
      last_rise = cyc;
    end
    if (hl_rst !== 1'b1 && hr_prev) begin
      `CHECK(cyc - last_rise, 118)
      period    = cyc - last_fall;
      last_fall = cyc;
      nfall++;
    end
    hr_prev = (hl_rst === 1'b1);
  end

  // Watchdog, some way beyond the planned run of about 60,000 cycles
  initial begin
    #(80000 * 40);
    fails++;
    stop_test();
  end

  initial begin
    void'($urandom(99));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    check_clocks();
    check_formats();
    run_lines(3'h1, 12'h000, 6, 909, 4);   // Short and long lines, square pixels
    run_lines(3'h3, 12'h000, 6, 1135, 0);  // Stable 625-line source
    @(posedge clk_sys);
    sc_lock <= 1'b0;                       // Burst lock lost mid-line
    repeat (3) @(negedge clk_sys);
    `CHECK(lock, 1'b0)
    @(posedge clk_sys);
    sc_lock <= 1'b1;
    run_lines(3'h1, 12'($urandom_range(880, 400)), 6, 910, 10);
    run_lines(3'h1, 12'h038e, 6, 914, 4);  // Target equals the shortest line
    repeat (300) @(posedge clk_sys);
    `CHECK(exp_q.size(), 0)
    stop_test();
  end
endmodule : testbench
